// [rtl/pw_pkg.sv]
// Constants, field layouts and carrier types for the three-phase
// power-to-pulse back end. Assumes one 100 MHz master clock and
// converter samples arriving on a strobe at the sample rate below.
// Overview of operation
// R1: High-pass each current channel so offsets add no dc power error.
// R2: Keep voltage and current channels phase matched up to 1 kHz.
// R3: First-order low-pass of each phase product, corner at 8 Hz.
// R4: Accumulate total power, pulse at each threshold crossing.
// R5: Calibration pulses use a threshold giving up to 160 times counter rate.
// R6: Sum-mode high gives arithmetic sum, low gives sum of magnitudes.
// R7: In magnitude mode every phase counts positive, pulses never stop.
// R8: Reverse detection always uses the arithmetic sum.
// R9: Reverse flag high for negative total, low for positive total.
// R10: Reverse flag changes only when a calibration pulse is issued; the code also clears it when all three phases are below no-load.
// R11: Reverse flag holds until total positive or all phases below no-load.
// R12: Both counter outputs give active-high pulses from long accumulation.
// R13: Base rate chosen by scale, high and low select inputs per table.
// R14: Base rates come from dividing the master clock.
// R15: Counter rate equals 6.181 times power sum times base rate over vref squared.
// R16: Host counting pulses picks an integration time for its accuracy.
// R17: Calibration equipment averages the calibration pulse frequency.
// R18: Data path held in reset, no pulses, while supply monitor reports low.
// R19: Phases below the no-load threshold are not accumulated.
// R20: Output pulses have fixed width shorter than the fastest period.
package pw_pkg;

  typedef struct packed {
    logic signed [15:0] volt;
    logic signed [15:0] curr;
  } pw_samp_t;

  localparam int PW_PWR_W = 34;
  localparam int PW_SUM_W = 36;
  localparam int PW_ACC_W = 48;

  localparam int unsigned PW_CLK_HZ = 100_000_000;
  localparam real PW_SAMPLE_HZ = 3200.0;
  localparam real PW_LPF_CORNER_HZ = 8.0;
  localparam real PW_TWO_PI = 6.2831853;
  localparam int PW_LPF_SHIFT =
    $clog2(int'(PW_SAMPLE_HZ / (PW_TWO_PI * PW_LPF_CORNER_HZ)));
  localparam int PW_HPF_SHIFT = 12;

  // Base rates, indexed by {high select, low select, scale select}
  localparam real PW_BASE_HZ [8] = '{2.24, 4.49, 1.12, 4.49, 5.09, 1.12, 0.56, 0.56};
  localparam int PW_SUBTICKS = 64;

  localparam real PW_GAIN = 6.181;
  localparam real PW_FS_V = 0.5;
  localparam real PW_VREF_V = 2.4;
  localparam real PW_VREF_CODE = 32768.0 * PW_VREF_V / PW_FS_V;
  localparam logic [47:0] PW_F_THRESH =
    48'(longint'(real'(PW_SUBTICKS) * PW_VREF_CODE * PW_VREF_CODE / PW_GAIN));
  localparam logic [47:0] PW_CF_RATIO = 48'h0000_0000_00a0;
  localparam logic [47:0] PW_CF_THRESH = PW_F_THRESH / PW_CF_RATIO;
  localparam logic [33:0] PW_NOLOAD = 34'h0_0010_0000;

  localparam real PW_F_PULSE_S = 0.1;
  localparam real PW_CF_PULSE_S = 0.0005;

  localparam int PW_ADR_W = 4;
  localparam logic [3:0] PW_REG_CTRL = 4'h0;
  localparam logic [3:0] PW_REG_STAT = 4'h4;
  localparam logic [31:0] PW_CTRL_RST = 32'h0000_0001;
  localparam int PW_CTRL_OUT_EN = 0;
  localparam int PW_STAT_REVERSE_POWER_FLAG = 0;
  localparam int PW_STAT_BELOW = 1;
  localparam int PW_STAT_SUPPLY = 4;
  localparam int PW_STAT_SEL = 5;

endpackage

// [rtl/pw_phase.sv]
// One phase: offset removal, product and 8 Hz smoothing.
// Assumes samples valid whenever stb is high; clr is synchronous.
module pw_phase
  import pw_pkg::*;
#(
  parameter int HPF_SHIFT = PW_HPF_SHIFT,
  parameter int LPF_SHIFT = PW_LPF_SHIFT
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic stb,
  input wire pw_pkg::pw_samp_t samp,
  output logic signed [PW_PWR_W-1:0] power,
  output logic below
);
  logic signed [31:0] dcv_q, dcv_d, dci_q, dci_d;
  logic signed [49:0] lpf_q, lpf_d;
  logic signed [PW_PWR_W-1:0] pwr_q, pwr_d;
  logic below_q, below_d;
  logic signed [31:0] xv, xi;
  logic signed [16:0] hv, hi;
  logic signed [33:0] prod;

  always_comb
  begin
    xv = 32'(samp.volt) <<< 16;
    xi = 32'(samp.curr) <<< 16;
    // Same filter on both channels: phase lead cancels at every frequency
    hv = 17'((xv - dcv_q) >>> 16); // [R2]
    hi = 17'((xi - dci_q) >>> 16); // [R1]
    prod = hv * hi;
    dcv_d = dcv_q;
    dci_d = dci_q;
    lpf_d = lpf_q;
    if (stb)
    begin
      dcv_d = dcv_q + ((xv - dcv_q) >>> HPF_SHIFT); // [R2]
      dci_d = dci_q + ((xi - dci_q) >>> HPF_SHIFT); // [R1]
      lpf_d = lpf_q + (((50'(prod) <<< 16) - lpf_q) >>> LPF_SHIFT); // [R3]
    end
    pwr_d = PW_PWR_W'(lpf_q >>> 16);
    below_d = (pwr_q[PW_PWR_W-1] ? -pwr_q : pwr_q) < signed'(PW_NOLOAD); // [R19]
    if (clr)
    begin
      dcv_d = '0;
      dci_d = '0;
      lpf_d = '0;
      pwr_d = '0;
      below_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dcv_q <= '0;
      dci_q <= '0;
      lpf_q <= '0;
      pwr_q <= '0;
      below_q <= 1'b1;
    end
    else
    begin
      dcv_q <= dcv_d;
      dci_q <= dci_d;
      lpf_q <= lpf_d;
      pwr_q <= pwr_d;
      below_q <= below_d;
    end
  end

  assign power = pwr_q;
  assign below = below_q;
endmodule // pw_phase

// [rtl/pw_dfc.sv]
// Digital-to-frequency converter: signed accumulator and pulse timer.
// A crossing while a pulse is high waits, which caps the pulse rate.
module pw_dfc
  import pw_pkg::*;
#(
  parameter int unsigned PULSE_CYC = 50000
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic tick,
  input wire logic signed [PW_SUM_W-1:0] power,
  input wire logic [PW_ACC_W-1:0] thresh,
  output logic pulse,
  output logic fire
);
  logic signed [PW_ACC_W-1:0] acc_q, acc_d;
  logic [31:0] wid_q, wid_d;
  logic pulse_q, pulse_d;

  always_comb
  begin
    acc_d = acc_q;
    wid_d = wid_q;
    fire = 1'b0;
    if (tick)
      acc_d = acc_q + PW_ACC_W'(power); // [R4]
    if (wid_q != 32'h0)
      wid_d = wid_q - 32'h1;
    else if (acc_d >= signed'(thresh))
    begin
      fire = 1'b1; // [R4]
      acc_d = acc_d - signed'(thresh);
      wid_d = 32'(PULSE_CYC); // [R20]
    end
    else if (acc_d <= -signed'(thresh))
    begin
      fire = 1'b1;
      acc_d = acc_d + signed'(thresh);
      wid_d = 32'(PULSE_CYC); // [R20]
    end
    if (clr)
    begin
      acc_d = '0;
      wid_d = '0;
      fire = 1'b0; // [R18]
    end
    pulse_d = wid_d != 32'h0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= '0;
      wid_q <= '0;
      pulse_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      wid_q <= wid_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;
endmodule // pw_dfc

// [rtl/pw_top.sv]
// Top of the power-to-pulse back end with a classic Wishbone slave.
// Assumes all pins synchronous to MCLK; SUPPLY_OK from the analog monitor.
//
// Implementation choices: the placing of the registers and register access over Wishbone.
module pw_top
  import pw_pkg::*;
#(
  parameter int unsigned CLK_HZ = PW_CLK_HZ,
  parameter int unsigned F_PULSE_CYC = int'(PW_F_PULSE_S * real'(PW_CLK_HZ)),
  parameter int unsigned CF_PULSE_CYC = int'(PW_CF_PULSE_S * real'(PW_CLK_HZ))
)
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SAMPLE_STB,
  input wire pw_pkg::pw_samp_t PHASE_A,
  input wire pw_pkg::pw_samp_t PHASE_B,
  input wire pw_pkg::pw_samp_t PHASE_C,
  input wire logic SUM_MODE_SELECT,
  input wire logic CAL_SCALE_SELECT,
  input wire logic RATE_SELECT_HIGH,
  input wire logic RATE_SELECT_LOW,
  input wire logic SUPPLY_OK,
  output logic COUNTER_PULSE_A,
  output logic COUNTER_PULSE_B,
  output logic CALIBRATION_PULSE_OUT,
  output logic REVERSE_POWER_FLAG,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [PW_ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O
);
  function automatic logic [31:0] div_of(input int k);
    return 32'(longint'(real'(CLK_HZ) / (PW_BASE_HZ[k] * real'(PW_SUBTICKS))));
  endfunction

  localparam logic [31:0] DIV_TAB [8] = '{div_of(0), div_of(1), div_of(2),
    div_of(3), div_of(4), div_of(5), div_of(6), div_of(7)};

  logic dp_clr;
  logic [2:0] sel;
  pw_samp_t samp [3];
  logic signed [PW_PWR_W-1:0] pwr [3];
  logic [2:0] below;
  logic signed [PW_SUM_W-1:0] arith, absol, total;
  logic tick;
  logic f_pulse, f_fire, cf_pulse, cf_fire;
  logic [31:0] div_q, div_d;
  logic rev_q, rev_d, side_q, side_d;
  logic fa_q, fa_d, fb_q, fb_d, cf_q, cf_d;
  logic [31:0] ctrl_q, ctrl_d, dat_q, dat_d;
  logic ack_q, ack_d;
  logic out_en;

  // Brown-out clears the whole path synchronously
  assign dp_clr = !SUPPLY_OK; // [R18]
  assign sel = {RATE_SELECT_HIGH, RATE_SELECT_LOW, CAL_SCALE_SELECT}; // [R13]
  assign samp[0] = PHASE_A;
  assign samp[1] = PHASE_B;
  assign samp[2] = PHASE_C;
  assign out_en = ctrl_q[PW_CTRL_OUT_EN];

  for (genvar p = 0; p < 3; p++)
  begin : g_phase
    pw_phase u_phase (
      .clk(MCLK),
      .rst_n(RST_N),
      .clr(dp_clr),
      .stb(SAMPLE_STB),
      .samp(samp[p]),
      .power(pwr[p]),
      .below(below[p])
    );
  end

  always_comb
  begin
    arith = '0;
    absol = '0;
    for (int p = 0; p < 3; p++)
    begin
      if (!below[p]) // [R19]
      begin
        arith = arith + PW_SUM_W'(pwr[p]); // [R8]
        absol = absol + (pwr[p][PW_PWR_W-1] ? -PW_SUM_W'(pwr[p])
                                             : PW_SUM_W'(pwr[p])); // [R7]
      end
    end
    total = SUM_MODE_SELECT ? arith : absol; // [R6]
  end

  // Sub-tick at base rate times PW_SUBTICKS; threshold folds in the gain
  always_comb
  begin
    div_d = div_q + 32'h1;
    tick = 1'b0;
    if (div_q >= DIV_TAB[sel] - 32'h1) // [R14]
    begin
      div_d = '0;
      tick = 1'b1; // [R15]
    end
    if (dp_clr)
    begin
      div_d = '0;
      tick = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      div_q <= '0;
    else
      div_q <= div_d;
  end

  pw_dfc #(.PULSE_CYC(F_PULSE_CYC)) u_dfc_f (
    .clk(MCLK),
    .rst_n(RST_N),
    .clr(dp_clr),
    .tick(tick),
    .power(total),
    .thresh(PW_F_THRESH),
    .pulse(f_pulse),
    .fire(f_fire)
  );

  pw_dfc #(.PULSE_CYC(CF_PULSE_CYC)) u_dfc_cf (
    .clk(MCLK),
    .rst_n(RST_N),
    .clr(dp_clr),
    .tick(tick),
    .power(total),
    .thresh(PW_CF_THRESH), // [R5]
    .pulse(cf_pulse),
    .fire(cf_fire)
  );

  // Counter pulses alternate between the two outputs for stepper drive
  always_comb
  begin
    side_d = side_q ^ f_fire;
    fa_d = f_pulse & !side_q & out_en; // [R12]
    fb_d = f_pulse & side_q & out_en; // [R12]
    cf_d = cf_pulse & out_en;
    rev_d = rev_q;
    if (cf_fire && arith < 0) // [R10]
      rev_d = 1'b1; // [R9]
    else if (cf_fire && arith > 0) // [R10]
      rev_d = 1'b0; // [R9]
    if (&below) // [R11]
      rev_d = 1'b0;
    if (dp_clr)
    begin
      side_d = 1'b0;
      fa_d = 1'b0;
      fb_d = 1'b0;
      cf_d = 1'b0;
      rev_d = 1'b0; // [R18]
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      side_q <= 1'b0;
      fa_q <= 1'b0;
      fb_q <= 1'b0;
      cf_q <= 1'b0;
      rev_q <= 1'b0;
    end
    else
    begin
      side_q <= side_d;
      fa_q <= fa_d;
      fb_q <= fb_d;
      cf_q <= cf_d;
      rev_q <= rev_d;
    end
  end

  assign COUNTER_PULSE_A = fa_q;
  assign COUNTER_PULSE_B = fb_q;
  assign CALIBRATION_PULSE_OUT = cf_q;
  assign REVERSE_POWER_FLAG = rev_q;

  // Slave: ack one cycle after request, write lands at the acked edge
  always_comb
  begin
    ack_d = WB_CYC_I & WB_STB_I & !ack_q;
    ctrl_d = ctrl_q;
    dat_d = dat_q;
    if (ack_q && WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == PW_REG_CTRL)
    begin
      for (int b = 0; b < 4; b++)
        if (WB_SEL_I[b])
          ctrl_d[8*b +: 8] = WB_DAT_I[8*b +: 8];
    end
    if (ack_d)
    begin
      dat_d = '0;
      case (WB_ADR_I)
        PW_REG_CTRL:
          dat_d = ctrl_q;
        PW_REG_STAT:
        begin
          dat_d[PW_STAT_REVERSE_POWER_FLAG] = rev_q;
          dat_d[PW_STAT_BELOW +: 3] = below;
          dat_d[PW_STAT_SUPPLY] = SUPPLY_OK;
          dat_d[PW_STAT_SEL +: 3] = sel;
        end
        default:
          dat_d = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack_q <= 1'b0;
      ctrl_q <= PW_CTRL_RST;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= ack_d;
      ctrl_q <= ctrl_d;
      dat_q <= dat_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
endmodule // pw_top

// [dv/pw_top_assertions.sv]
// Port checker for pw_top: pulse widths, order, reverse flag, bus answers.
// Bound to every pw_top; one clock, async active-low reset.
module pw_checker
  import pw_pkg::*;
#(
  parameter int unsigned F_PULSE_CYC = 20
)
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SUPPLY_OK,
  input wire logic COUNTER_PULSE_A,
  input wire logic COUNTER_PULSE_B,
  input wire logic CALIBRATION_PULSE_OUT,
  input wire logic REVERSE_POWER_FLAG,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [pw_pkg::PW_ADR_W-1:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  logic [31:0] wid_q, wid_d;
  logic last_a_q, last_a_d;
  logic req;
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  always_comb
  begin
    wid_d = COUNTER_PULSE_A ? wid_q + 32'h1 : 32'h0;
    last_a_d = COUNTER_PULSE_A ? 1'b1 : (COUNTER_PULSE_B ? 1'b0 : last_a_q);
    if (!SUPPLY_OK)
      last_a_d = 1'b0;
  end
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
    begin
      wid_q <= 32'h0;
      last_a_q <= 1'b0;
    end
    else
    begin
      wid_q <= wid_d;
      last_a_q <= last_a_d;
    end
  // Truncation by a supply drop is legal, so those attempts are dropped
  property p_cf_width;
    disable iff (!RST_N || !SUPPLY_OK)
    $rose(CALIBRATION_PULSE_OUT) |-> CALIBRATION_PULSE_OUT [*4] ##[0:2] !CALIBRATION_PULSE_OUT;
  endproperty
  a_cf_width: assert property (p_cf_width) else $error("cal pulse width wrong");
  property p_f_width;
    disable iff (!RST_N || !SUPPLY_OK)
    $fell(COUNTER_PULSE_A) |-> wid_q + 1 >= F_PULSE_CYC && wid_q <= F_PULSE_CYC + 1;
  endproperty
  a_f_width: assert property (p_f_width) else $error("counter pulse width wrong");
  property p_alt;
    $rose(COUNTER_PULSE_A) |-> !last_a_q && !COUNTER_PULSE_B;
  endproperty
  a_alt: assert property (p_alt) else $error("counter pulses out of turn");
  property p_reverse_power_flag_on_cf;
    $rose(REVERSE_POWER_FLAG) |-> ##[0:4] $rose(CALIBRATION_PULSE_OUT);
  endproperty
  a_reverse_power_flag_on_cf: assert property (p_reverse_power_flag_on_cf) else $error("reverse set off cal pulse");
  property p_supply;
    !SUPPLY_OK |=> !CALIBRATION_PULSE_OUT && !COUNTER_PULSE_A && !COUNTER_PULSE_B
      && !REVERSE_POWER_FLAG;
  endproperty
  a_supply: assert property (p_supply) else $error("output active in supply reset");
  property p_ack;
    req |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer timing wrong");
  property p_unmapped;
    req && !WB_WE_I && WB_ADR_I[3] |=> WB_DAT_O == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_stat;
    req && !WB_WE_I && WB_ADR_I == 4'h4 |=> WB_DAT_O[0] == $past(REVERSE_POWER_FLAG);
  endproperty
  a_stat: assert property (p_stat) else $error("status reverse bit wrong");
endmodule // pw_checker

bind pw_top pw_checker #(.F_PULSE_CYC(F_PULSE_CYC)) pw_checker_i (.*);

// [dv/pw_pulse_meter.sv]
// Far-side pulse counter: counts rising edges of the three pulse outputs.
// Assumes pulses synchronous to clk; counts never reset.
module pw_pulse_meter
(
  input wire logic clk,
  input wire logic cf,
  input wire logic fa,
  input wire logic fb,
  output int n_cf,
  output int n_a,
  output int n_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] prev = 3'h0;
  initial {n_cf, n_a, n_b} = '0;
  // Only long-window differences are used: cal ripple averages out
  always @(posedge clk)
  begin
    prev <= {cf, fa, fb};
    n_cf <= n_cf + int'(cf && !prev[2]);
    n_a <= n_a + int'(fa && !prev[1]);
    n_b <= n_b + int'(fb && !prev[0]);
  end
endmodule // pw_pulse_meter

// [dv/test_polyphase_power_to_pulse.sv]
// Bench for pw_top: square-wave phases, rate table, reverse flag, registers.
// Design scaled to CLK_HZ 5000 so pulses come every few thousand cycles.
module test_polyphase_power_to_pulse
  import pw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK = 0, RST_N = 0, SAMPLE_STB = 0, SUM_MODE_SELECT = 1, SUPPLY_OK = 1;
  logic CAL_SCALE_SELECT = 0, RATE_SELECT_HIGH = 0, RATE_SELECT_LOW = 0;
  pw_samp_t PHASE_A = '0, PHASE_B = '0, PHASE_C = '0;
  logic WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, WB_ACK_O;
  logic [3:0] WB_ADR_I = '0, WB_SEL_I = 4'hf;
  logic [31:0] WB_DAT_I = '0, WB_DAT_O;
  logic COUNTER_PULSE_A, COUNTER_PULSE_B, CALIBRATION_PULSE_OUT, REVERSE_POWER_FLAG;
  logic signed [15:0] amp = '0;
  logic [2:0] neg = '0;
  logic [7:0] sc = '0;
  int failures = 0, tests_run = 0, n_cf, n_a, n_b, c, f;
  always #5 MCLK = ~MCLK;
  pw_top #(.CLK_HZ(5000), .F_PULSE_CYC(20), .CF_PULSE_CYC(5)) pw_top_i (.*);
  pw_pulse_meter pw_pulse_meter_i (.clk(MCLK), .cf(CALIBRATION_PULSE_OUT),
    .fa(COUNTER_PULSE_A), .fb(COUNTER_PULSE_B), .n_cf(n_cf), .n_a(n_a), .n_b(n_b));
  // Zero-mean square wave, so the offset filter leaves the power intact
  function automatic pw_samp_t mk(input logic r);
    pw_samp_t s;
    s.volt = sc[6] ? amp : -amp;
    s.curr = r ? -s.volt : s.volt;
    return s;
  endfunction
  always @(posedge MCLK)
  begin
    sc <= sc + 8'h1;
    SAMPLE_STB <= (sc[1:0] == 2'h0);
    PHASE_A <= mk(neg[0]);
    PHASE_B <= mk(neg[1]);
    PHASE_C <= mk(neg[2]);
  end
  task finish_test;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Quantised sub-ticks and filter settling leave some slack
  task chkr(input int got, input real e);
    tests_run++;
    if (got < 0.8 * e - 2.0 || got > 1.2 * e + 2.0)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, int'(e));
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    i = 0;
    @(posedge MCLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    do
    begin
      @(posedge MCLK);
      i++;
    end
    while (WB_ACK_O !== 1'b1 && i < 20);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    if (i >= 20)
    begin
      failures++;
      finish_test;
    end
  endtask
  task meas(input int win);
    int c0, f0;
    c0 = n_cf;
    f0 = n_a + n_b;
    repeat (win) @(posedge MCLK);
    c = n_cf - c0;
    f = n_a + n_b - f0;
  endtask
  // Cal rate: 160 x 6.181 x sum(Vrms*Irms) x base / vref^2, amp 0.25 V
  function automatic real ecf(input int n, input int idx, input int win);
    return 160.0 * 6.181 * 0.0625 * n * PW_BASE_HZ[idx] * win / (2.4 * 2.4 * 5000.0);
  endfunction
  task t_regs;
    logic [31:0] q;
    wb(1'b0, PW_REG_CTRL, 32'h0, q);
    chk(q, 32'h1);
    wb(1'b1, PW_REG_STAT, 32'hffff_ffff, q);
    wb(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, PW_REG_STAT, 32'h0, q);
    chk(q & 32'hff, 32'h1e);
    SUPPLY_OK <= 1'b0;
    amp <= 16'sh4000;
    wb(1'b1, PW_REG_CTRL, 32'h0, q);
    meas(1000);
    chk(c + f, 32'h0);
    chk(REVERSE_POWER_FLAG, 1'b0);
    SUPPLY_OK <= 1'b1;
    meas(2000);
    chk(c + f, 32'h0);
    SUPPLY_OK <= 1'b0;
    wb(1'b1, PW_REG_CTRL, 32'h1, q);
    SUPPLY_OK <= 1'b1;
  endtask
  task t_rates;
    for (int i = 0; i < 8; i++)
    begin
      {RATE_SELECT_HIGH, RATE_SELECT_LOW, CAL_SCALE_SELECT} <= 3'(i);
      repeat (500) @(posedge MCLK);
      meas(4000);
      chkr(c, ecf(3, i, 4000));
    end
    {RATE_SELECT_HIGH, RATE_SELECT_LOW, CAL_SCALE_SELECT} <= 3'h4;
    meas(20000);
    chkr(f, ecf(3, 4, 20000) / 160.0);
    chk(REVERSE_POWER_FLAG, 1'b0);
  endtask
  task t_reverse;
    neg <= 3'b011;
    meas(1000);
    meas(6000);
    chkr(c, ecf(1, 4, 6000));
    chk(REVERSE_POWER_FLAG, 1'b1);
    SUM_MODE_SELECT <= 1'b0;
    meas(1000);
    meas(6000);
    chkr(c, ecf(3, 4, 6000));
    chk(REVERSE_POWER_FLAG, 1'b1);
    neg <= 3'b000;
    meas(1000);
    chk(REVERSE_POWER_FLAG, 1'b0);
    SUM_MODE_SELECT <= 1'b1;
    neg <= 3'b011;
    meas(1000);
    amp <= 16'sh0;
    meas(2000);
    meas(2000);
    chk(c + f, 32'h0);
    chk(REVERSE_POWER_FLAG, 1'b0);
  endtask
  initial
  begin
    repeat (5) @(posedge MCLK);
    RST_N <= 1'b1;
    t_regs;
    t_rates;
    t_reverse;
    finish_test;
  end
endmodule // test_polyphase_power_to_pulse
